// ==== design/nrc_params.svh ====
`ifndef NRC_PARAMS_SVH
`define NRC_PARAMS_SVH

// ----------------------------------------
// Register numbers
// ----------------------------------------
`define NRC_REG_RESET_CTRL 8'h50
`define NRC_REG_OSC_FREQ 8'h51
`define NRC_REG_LINK_CTRL 8'h80

// ----------------------------------------
// Reset and mode control fields
// ----------------------------------------
`define NRC_RC_SYS_BIT 0
`define NRC_RC_TILE_BIT 1
`define NRC_RC_USB_EN_BIT 2
`define NRC_RC_USB_ACC_BIT 3
`define NRC_RC_MODE_LSB 16
`define NRC_RC_MODE_MSB 17
`define NRC_RC_MODE_TRI_BIT 24
`define NRC_RC_MODE_RESET 2'h0
`define NRC_RC_MODE_TRI_RESET 1'h0

// ----------------------------------------
// Oscillator frequency field
// ----------------------------------------
`define NRC_FREQ_MSB 6
`define NRC_FREQ_RESET 7'h19
`define NRC_FREQ_MIN 7'h05
`define NRC_FREQ_MAX 7'h64
`define NRC_USB_FREQ_A 7'h0C
`define NRC_USB_FREQ_B 7'h18
`define NRC_USB_FREQ_C 7'h30
`define NRC_USB_FREQ_D 7'h60

// ----------------------------------------
// Link control and status fields
// ----------------------------------------
`define NRC_LK_ERR_BIT 27
`define NRC_LK_ISSUED_BIT 26
`define NRC_LK_HELD_BIT 25
`define NRC_LK_LINK_GREETING_TOKEN_BIT 24
`define NRC_LK_RXRST_BIT 23
`define NRC_LK_SYM_LSB 11
`define NRC_LK_SYM_MSB 21
`define NRC_LK_TOK_LSB 0
`define NRC_LK_TOK_MSB 10
`define NRC_LK_GAP_RESET 11'h001

// ----------------------------------------
// Timing
// ----------------------------------------
`define NRC_SYS_RESET_CYCLES 524288
`define NRC_TILE_RESET_US 16
`define NRC_WDOG_TICK_US 1000

`endif

// ==== design/nrc_pkg.sv ====
package nrc_pkg;

    // ----------------------------------------
    // Configuration packet request and answer
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic resp_wanted;
        logic [7:0] addr;
        logic [31:0] wdata;
    } nrc_cfg_req_t;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [31:0] rdata;
    } nrc_cfg_rsp_t;

    // ----------------------------------------
    // Link core events and controls
    // ----------------------------------------
    typedef struct packed {
        logic rx_error;
        logic credit_rx;
        logic credit_tx;
        logic in_token;
    } nrc_link_evt_t;

    typedef struct packed {
        logic link_greeting_token;
        logic rx_reset;
        logic sym_tick;
        logic token_ready;
    } nrc_link_ctl_t;

    typedef enum {
        NRC_TX_IDLE,
        NRC_TX_TOKEN,
        NRC_TX_GAP
    } nrc_tx_state_t;

endpackage : nrc_pkg

// ==== design/nrc_hold_timer.sv ====
`timescale 1ns/1ns

module nrc_hold_timer #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [W-1:0] len,
    output logic active_q
);
    logic [W-1:0] cnt_q;

    generate
        if (W < 2) begin : g_bad
            $error("nrc_hold_timer: W too small");
        end
    endgenerate

    // Restart on every start so a held source stretches the pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end else if (start) begin
            cnt_q <= len;
            active_q <= (len != '0);
        end else begin
            cnt_q <= (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
            active_q <= (cnt_q > W'(1));
        end
    end

endmodule : nrc_hold_timer

// ==== design/nrc_ctrl.sv ====
`timescale 1ns/1ns
`include "nrc_params.svh"

// Notes on behaviour
// - Two reset scopes: system and tile.
// - Pin, brown-out, watchdog raise system reset.
// - Sleep or clock change raise tile reset.
// - System reset held fixed oscillator-cycle count.
// - Control bit 0 starts system reset, self-clears.
// - Control bit 1 starts tile reset, self-clears.
// - Reset-trigger writes never get a response.
// - Bit 2 enables USB block, clear resets.
// - Bit 3 gates USB register access.
// - Mode pin field plus tristate bit.
// - Frequency 5 to 100 only, else NACK.
// - Tile reset delay, ticks, USB check from frequency.
// - Link error bit sets on event, read-clears.
// - Status bits show issued and held credit.
// - Greeting bit clears held credit, sends greeting.
// - Receiver reset bit, self-clearing.
// - Symbol and token spacing from gap fields.
// - Node lock blocks link register writes.
module nrc_ctrl #(
    parameter int SYS_RESET_CYCLES = `NRC_SYS_RESET_CYCLES,
    parameter int TILE_RESET_US = `NRC_TILE_RESET_US,
    parameter int WDOG_TICK_US = `NRC_WDOG_TICK_US
) (
    input wire logic clk,
    input wire logic reset,
    input nrc_pkg::nrc_cfg_req_t cfg_req,
    output nrc_pkg::nrc_cfg_rsp_t cfg_rsp,
    input wire logic ext_reset_n,
    input wire logic brownout,
    input wire logic watchdog_expired,
    input wire logic sleep_seq,
    input wire logic clk_src_change,
    input wire logic node_cfg_lock,
    input nrc_pkg::nrc_link_evt_t link_evt,
    output nrc_pkg::nrc_link_ctl_t link_ctl,
    output logic sys_reset_out,
    output logic tile_reset_out,
    output logic usb_enable,
    output logic usb_if_reset,
    output logic usb_reg_access_en,
    output logic [1:0] mode_pins,
    output logic mode_pins_oe,
    output logic usb_clk_valid,
    output logic wdog_tick
);
    import nrc_pkg::*;

    localparam int TW = 20;
    localparam int MW = 10;

    generate
        if (SYS_RESET_CYCLES < 1 || SYS_RESET_CYCLES >= (1 << TW)) begin : g_bad_sys
            $error("nrc_ctrl: SYS_RESET_CYCLES out of range");
        end
        if (TILE_RESET_US < 1 || TILE_RESET_US > 1024) begin : g_bad_tile
            $error("nrc_ctrl: TILE_RESET_US out of range");
        end
        if (WDOG_TICK_US < 1 || WDOG_TICK_US > (1 << MW)) begin : g_bad_wdog
            $error("nrc_ctrl: WDOG_TICK_US out of range");
        end
    endgenerate

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic usb_en_q;
    logic usb_acc_q;
    logic [1:0] mode_q;
    logic mode_tri_q;
    logic [6:0] freq_q;
    logic err_q;
    logic issued_q;
    logic held_q;
    logic [10:0] sym_gap_q;
    logic [10:0] tok_gap_q;
    logic sys_hold;
    logic tile_hold;
    logic regs_rst;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire hit_rc = cfg_req.addr == `NRC_REG_RESET_CTRL;
    wire hit_fq = cfg_req.addr == `NRC_REG_OSC_FREQ;
    wire hit_lk = cfg_req.addr == `NRC_REG_LINK_CTRL;
    wire mapped = hit_rc | hit_fq | hit_lk;
    wire wr = cfg_req.valid & cfg_req.write & ~sys_hold;
    wire rd = cfg_req.valid & ~cfg_req.write;
    wire wr_rc = wr & hit_rc;
    wire [6:0] wfreq = cfg_req.wdata[`NRC_FREQ_MSB:0];
    wire freq_ok = (wfreq >= `NRC_FREQ_MIN) && (wfreq <= `NRC_FREQ_MAX);
    wire wr_fq = wr & hit_fq & freq_ok;
    wire wr_lk = wr & hit_lk & ~node_cfg_lock;
    wire rd_lk = rd & hit_lk;
    wire sw_sys = wr_rc & cfg_req.wdata[`NRC_RC_SYS_BIT];
    wire sw_tile = wr_rc & cfg_req.wdata[`NRC_RC_TILE_BIT];
    wire link_greeting_token = wr_lk & cfg_req.wdata[`NRC_LK_LINK_GREETING_TOKEN_BIT];
    wire rx_rst = wr_lk & cfg_req.wdata[`NRC_LK_RXRST_BIT];

    // ----------------------------------------
    // Reset sources
    // ----------------------------------------
    // system sources
    wire sys_start = ~ext_reset_n | brownout | watchdog_expired | sw_sys;
    wire tile_start = sleep_seq | clk_src_change | sw_tile;
    wire [TW-1:0] tile_len = TW'(freq_q * TILE_RESET_US);
    // Register bank falls under system reset scope
    assign regs_rst = reset | sys_hold;

    nrc_hold_timer #(.W(TW)) u_sys_timer (
        .clk(clk),
        .reset(reset),
        .start(sys_start),
        .len(TW'(SYS_RESET_CYCLES)),
        .active_q(sys_hold)
    );
    nrc_hold_timer #(.W(TW)) u_tile_timer (
        .clk(clk),
        .reset(regs_rst),
        .start(tile_start),
        .len(tile_len),
        .active_q(tile_hold)
    );

    assign sys_reset_out = sys_hold;
    always_ff @(posedge clk) begin
        if (reset) begin
            tile_reset_out <= 1'b0;
        end else begin
            tile_reset_out <= tile_hold | sys_hold;
        end
    end

    // ----------------------------------------
    // Reset and mode control register
    // ----------------------------------------
    // stored fields
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            usb_en_q <= 1'b0;
            usb_acc_q <= 1'b0;
            mode_q <= `NRC_RC_MODE_RESET;
            mode_tri_q <= `NRC_RC_MODE_TRI_RESET;
        end else if (wr_rc) begin
            usb_en_q <= cfg_req.wdata[`NRC_RC_USB_EN_BIT];
            usb_acc_q <= cfg_req.wdata[`NRC_RC_USB_ACC_BIT];
            mode_q <= cfg_req.wdata[`NRC_RC_MODE_MSB:`NRC_RC_MODE_LSB];
            mode_tri_q <= cfg_req.wdata[`NRC_RC_MODE_TRI_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            usb_enable <= 1'b0;
            usb_if_reset <= 1'b1;
            usb_reg_access_en <= 1'b0;
            mode_pins <= `NRC_RC_MODE_RESET;
            mode_pins_oe <= 1'b0;
        end else begin
            usb_enable <= usb_en_q;
            usb_if_reset <= ~usb_en_q;
            usb_reg_access_en <= usb_acc_q;
            mode_pins <= mode_q;
            mode_pins_oe <= ~mode_tri_q;
        end
    end

    // ----------------------------------------
    // Oscillator frequency register
    // ----------------------------------------
    // store valid only
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            freq_q <= `NRC_FREQ_RESET;
        end else if (wr_fq) begin
            freq_q <= wfreq;
        end
    end

    wire usb_ok = (freq_q == `NRC_USB_FREQ_A) || (freq_q == `NRC_USB_FREQ_B) ||
        (freq_q == `NRC_USB_FREQ_C) || (freq_q == `NRC_USB_FREQ_D);
    // ----------------------------------------
    // Watchdog tick from frequency
    // ----------------------------------------
    // Microsecond prescaler follows the field, so a wrong field skews the tick
    logic [6:0] us_cnt_q;
    logic [MW-1:0] ms_cnt_q;
    wire us_tick = us_cnt_q >= freq_q - 7'h01;
    wire ms_wrap = us_tick && (ms_cnt_q >= MW'(WDOG_TICK_US - 1));
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            us_cnt_q <= '0;
            ms_cnt_q <= '0;
            wdog_tick <= 1'b0;
            usb_clk_valid <= 1'b0;
        end else begin
            us_cnt_q <= us_tick ? 7'h00 : us_cnt_q + 7'h01;
            ms_cnt_q <= ms_wrap ? '0 : (us_tick ? ms_cnt_q + MW'(1) : ms_cnt_q);
            wdog_tick <= ms_wrap;
            usb_clk_valid <= usb_ok;
        end
    end

    // ----------------------------------------
    // Link control and status register
    // ----------------------------------------
    wire [10:0] sym_gap = (sym_gap_q == 11'h000) ? 11'h001 : sym_gap_q;
    wire [10:0] tok_gap = (tok_gap_q == 11'h000) ? 11'h001 : tok_gap_q;
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            sym_gap_q <= `NRC_LK_GAP_RESET;
            tok_gap_q <= `NRC_LK_GAP_RESET;
        end else if (wr_lk) begin
            sym_gap_q <= cfg_req.wdata[`NRC_LK_SYM_MSB:`NRC_LK_SYM_LSB];
            tok_gap_q <= cfg_req.wdata[`NRC_LK_TOK_MSB:`NRC_LK_TOK_LSB];
        end
    end

    // Events win over clears so none is lost
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            err_q <= 1'b0;
            issued_q <= 1'b0;
            held_q <= 1'b0;
        end else begin
            err_q <= link_evt.rx_error | (err_q & ~rd_lk);
            issued_q <= link_evt.credit_tx | (issued_q & ~rx_rst);
            held_q <= link_evt.credit_rx | (held_q & ~link_greeting_token);
        end
    end

    // ----------------------------------------
    // Transmit spacing
    // ----------------------------------------
    nrc_tx_state_t tx_q;
    nrc_tx_state_t tx_d;
    logic [10:0] gap_cnt_q;
    logic [10:0] gap_cnt_d;
    logic sym_tick_d;
    always_comb begin
        tx_d = tx_q;
        gap_cnt_d = gap_cnt_q;
        sym_tick_d = 1'b0;
        unique case (tx_q)
            NRC_TX_IDLE: begin
                if (link_evt.in_token) begin
                    tx_d = NRC_TX_TOKEN;
                    gap_cnt_d = sym_gap;
                end
            end
            NRC_TX_TOKEN: begin
                if (!link_evt.in_token) begin
                    tx_d = NRC_TX_GAP;
                    gap_cnt_d = tok_gap;
                end else if (gap_cnt_q <= 11'h001) begin
                    sym_tick_d = 1'b1;
                    gap_cnt_d = sym_gap;
                end else begin
                    gap_cnt_d = gap_cnt_q - 11'h001;
                end
            end
            NRC_TX_GAP: begin
                if (gap_cnt_q <= 11'h001) begin
                    tx_d = NRC_TX_IDLE;
                end else begin
                    gap_cnt_d = gap_cnt_q - 11'h001;
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (regs_rst) begin
            tx_q <= NRC_TX_IDLE;
            gap_cnt_q <= '0;
            link_ctl <= '0;
        end else begin
            tx_q <= tx_d;
            gap_cnt_q <= gap_cnt_d;
            link_ctl.link_greeting_token <= link_greeting_token;
            link_ctl.rx_reset <= rx_rst;
            link_ctl.sym_tick <= sym_tick_d;
            link_ctl.token_ready <= (tx_d == NRC_TX_IDLE);
        end
    end

    // ----------------------------------------
    // Configuration answer
    // ----------------------------------------
    // triggers and reserved read zero
    wire [31:0] rd_rc = {7'h00, mode_tri_q, 6'h00, mode_q, 12'h000, usb_acc_q, usb_en_q, 2'b00};
    wire [31:0] rd_fq = {25'h0000000, freq_q};
    wire [31:0] rd_lkv = {4'h0, err_q, issued_q, held_q, 3'b000, sym_gap_q, tok_gap_q};
    wire [31:0] rdata = hit_rc ? rd_rc : (hit_fq ? rd_fq : (hit_lk ? rd_lkv : 32'h00000000));
    wire silent = wr_rc & (cfg_req.wdata[`NRC_RC_SYS_BIT] | cfg_req.wdata[`NRC_RC_TILE_BIT]);
    wire rsp_fire = rd | (wr & cfg_req.resp_wanted & ~silent);
    wire nack = ~mapped | (wr & hit_fq & ~freq_ok) | (wr & hit_lk & node_cfg_lock);

    always_ff @(posedge clk) begin
        if (regs_rst) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp.valid <= rsp_fire;
            cfg_rsp.ack <= rsp_fire & ~nack;
            cfg_rsp.rdata <= rd ? rdata : 32'h00000000;
        end
    end

endmodule : nrc_ctrl

// ==== tb/nrc_link_partner.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Remote link endpoint
// ----------------------------------------
module nrc_link_partner (
    input wire logic clk,
    input wire logic reset,
    input nrc_pkg::nrc_link_ctl_t link_ctl,
    input wire logic slow,
    input wire logic err_cmd,
    input wire logic tok_cmd,
    output nrc_pkg::nrc_link_evt_t link_evt
);
    import nrc_pkg::*;
    int wait_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q <= 0;
        end else if (link_ctl.link_greeting_token) begin
            wait_q <= slow ? 9 : 2;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
        end
    end
    // Credit flows both ways once the handshake lands
    assign link_evt = {err_cmd, wait_q == 1, wait_q == 1, tok_cmd};
endmodule : nrc_link_partner

// ==== tb/nrc_ctrl_assertions.sv ====
`timescale 1ns/1ns
module nrc_ctrl_assertions #(
    parameter int SYS_RESET_CYCLES = 16
) (
    input wire logic clk,
    input wire logic reset,
    input nrc_pkg::nrc_cfg_req_t cfg_req,
    input nrc_pkg::nrc_cfg_rsp_t cfg_rsp,
    input wire logic ext_reset_n,
    input wire logic brownout,
    input wire logic watchdog_expired,
    input wire logic node_cfg_lock,
    input nrc_pkg::nrc_link_ctl_t link_ctl,
    input wire logic sys_reset_out,
    input wire logic tile_reset_out
);
    import nrc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [19:0] since_q;
    wire logic sw_sys = cfg_req.valid && cfg_req.write && cfg_req.addr == 8'h50
        && cfg_req.wdata[0] && !sys_reset_out;
    wire logic start = !ext_reset_n || brownout || watchdog_expired || sw_sys;
    // Restart count; saturates so long idles stay legal
    always_ff @(posedge clk) begin
        if (reset || start) begin
            since_q <= 20'h0;
        end else if (since_q != 20'hFFFFF) begin
            since_q <= since_q + 20'h1;
        end
    end
    sequence s_wr(logic [7:0] a);
        cfg_req.valid && cfg_req.write && cfg_req.addr == a && !sys_reset_out;
    endsequence
    sequence s_pulse(logic p);
        p ##1 !p;
    endsequence
    chk_read_answered: assert property (
        (cfg_req.valid && !cfg_req.write && !sys_reset_out) |=> cfg_rsp.valid)
        else $error("read not answered");
    chk_trigger_silent: assert property (
        s_wr(8'h50) ##0 cfg_req.wdata[1:0] != 2'h0 |=> !cfg_rsp.valid)
        else $error("trigger write answered");
    chk_sys_start: assert property (start |=> sys_reset_out)
        else $error("system reset not raised");
    chk_sys_length: assert property (
        $fell(sys_reset_out) |-> since_q == SYS_RESET_CYCLES)
        else $error("system reset length wrong");
    chk_tile_covers: assert property (sys_reset_out |=> tile_reset_out)
        else $error("tile reset missing in system reset");
    chk_freq_nack: assert property (
        s_wr(8'h51) ##0 (cfg_req.wdata[6:0] < 7'h05 || cfg_req.wdata[6:0] > 7'h64)
        ##0 cfg_req.resp_wanted |=> cfg_rsp.valid && !cfg_rsp.ack)
        else $error("bad frequency accepted");
    chk_link_greeting_token_pulse: assert property (
        s_wr(8'h80) ##0 cfg_req.wdata[24] && !node_cfg_lock |=> s_pulse(link_ctl.link_greeting_token))
        else $error("greeting pulse wrong");
    chk_rx_reset: assert property (
        s_wr(8'h80) ##0 cfg_req.wdata[23] && !node_cfg_lock |=> link_ctl.rx_reset)
        else $error("receiver reset missing");
    chk_lock_block: assert property (
        s_wr(8'h80) ##0 node_cfg_lock |=> !link_ctl.link_greeting_token && !link_ctl.rx_reset)
        else $error("locked write took effect");
endmodule : nrc_ctrl_assertions

bind nrc_ctrl nrc_ctrl_assertions #(.SYS_RESET_CYCLES(SYS_RESET_CYCLES)) nrc_ctrl_assertions_i (
    .clk(clk),
    .reset(reset),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .ext_reset_n(ext_reset_n),
    .brownout(brownout),
    .watchdog_expired(watchdog_expired),
    .node_cfg_lock(node_cfg_lock),
    .link_ctl(link_ctl),
    .sys_reset_out(sys_reset_out),
    .tile_reset_out(tile_reset_out)
);

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import nrc_pkg::*;
    logic clk;
    logic reset;
    nrc_cfg_req_t cfg_req;
    nrc_cfg_rsp_t cfg_rsp;
    nrc_link_evt_t link_evt;
    nrc_link_ctl_t link_ctl;
    logic [4:0] src;
    logic node_cfg_lock, slow, err_cmd, tok_cmd;
    logic sys_reset_out, tile_reset_out, usb_enable, usb_if_reset, usb_reg_access_en;
    logic [1:0] mode_pins;
    logic mode_pins_oe, usb_clk_valid, wdog_tick;
    int mismatches;
    int checked;
    wire logic [3:0] mon = {wdog_tick, link_ctl.sym_tick, tile_reset_out, sys_reset_out};

    nrc_ctrl #(.SYS_RESET_CYCLES(16), .TILE_RESET_US(1), .WDOG_TICK_US(2)) nrc_ctrl_i (
        .clk(clk), .reset(reset), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .ext_reset_n(~src[0]), .brownout(src[1]), .watchdog_expired(src[2]),
        .sleep_seq(src[3]), .clk_src_change(src[4]), .node_cfg_lock(node_cfg_lock),
        .link_evt(link_evt), .link_ctl(link_ctl), .sys_reset_out(sys_reset_out),
        .tile_reset_out(tile_reset_out), .usb_enable(usb_enable),
        .usb_if_reset(usb_if_reset), .usb_reg_access_en(usb_reg_access_en),
        .mode_pins(mode_pins), .mode_pins_oe(mode_pins_oe),
        .usb_clk_valid(usb_clk_valid), .wdog_tick(wdog_tick));
    nrc_link_partner nrc_link_partner_i (.clk(clk), .reset(reset), .link_ctl(link_ctl),
        .slow(slow), .err_cmd(err_cmd), .tok_cmd(tok_cmd), .link_evt(link_evt));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [33:0] r);
        @(negedge clk);
        cfg_req = '{1'b1, w, 1'b1, a, d};
        @(negedge clk);
        cfg_req.valid = 1'b0;
        r = cfg_rsp;
    endtask : req

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [33:0] r;
        req(1'b0, a, 32'h0, r);
        chk("read", {2'b11, exp}, r);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic [33:0] r;
        req(1'b1, a, d, r);
        chk("write answer", exp, {r[33], r[32] & r[33]});
    endtask : wr

    task automatic run_len(input int w, input logic lvl, output int n);
        n = 0;
        for (int i = 0; i < 200 && mon[w] !== lvl; i++) @(negedge clk);
        while (mon[w] === lvl && n < 200) begin
            n++;
            @(negedge clk);
        end
    endtask : run_len

    task automatic fire(input int k);
        logic [33:0] r;
        if (k >= 5) begin
            req(1'b1, 8'h50, 32'h1 << (k - 5), r);
            chk("trigger answer", 32'h0, r[33]);
        end else begin
            @(negedge clk);
            src = 5'h1 << k;
            @(negedge clk);
            src = 5'h00;
        end
    endtask : fire

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [33:0] r;
        rd(8'h50, 32'h0);
        rd(8'h51, 32'h19);
        rd(8'h80, 32'h801);
        req(1'b0, 8'h52, 32'h0, r);
        chk("unmapped", {2'b10, 32'h0}, r);
        wr(8'h50, 32'h0103_000C, 2'b11);
        @(negedge clk);
        chk("usb mode pins", 6'b101110, {usb_enable, usb_if_reset, usb_reg_access_en,
            mode_pins, mode_pins_oe});
        rd(8'h50, 32'h0103_000C);
        wr(8'h50, 32'hFEFC_FFF0, 2'b11);
        rd(8'h50, 32'h0);
        chk("usb off", 6'b010001, {usb_enable, usb_if_reset, usb_reg_access_en,
            mode_pins, mode_pins_oe});
    endtask : t_regs

    task automatic t_freq();
        logic [6:0] v [6] = '{7'h04, 7'h05, 7'h64, 7'h65, 7'h0C, 7'h30};
        logic [6:0] f;
        logic ok;
        int n;
        f = 7'h19;
        foreach (v[i]) begin
            ok = v[i] >= 7'h05 && v[i] <= 7'h64;
            if (ok) f = v[i];
            wr(8'h51, {25'h0, v[i]}, {1'b1, ok});
            rd(8'h51, {25'h0, f});
            chk("usb clock", f == 7'h0C || f == 7'h30, usb_clk_valid);
        end
        run_len(3, 1'b1, n);
        run_len(3, 1'b0, n);
        chk("tick gap", 32'd95, n);
        wr(8'h51, 32'h19, 2'b11);
    endtask : t_freq

    task automatic t_link();
        int n;
        wr(8'h80, 32'h0100_0801, 2'b11);
        repeat (6) @(negedge clk);
        rd(8'h80, 32'h0600_0801);
        slow = 1'b1;
        wr(8'h80, 32'h0100_0801, 2'b11);
        rd(8'h80, 32'h0400_0801);
        repeat (12) @(negedge clk);
        rd(8'h80, 32'h0600_0801);
        slow = 1'b0;
        wr(8'h80, 32'h0080_0801, 2'b11);
        rd(8'h80, 32'h0200_0801);
        @(negedge clk);
        err_cmd = 1'b1;
        @(negedge clk);
        err_cmd = 1'b0;
        rd(8'h80, 32'h0A00_0801);
        rd(8'h80, 32'h0200_0801);
        node_cfg_lock = 1'b1;
        wr(8'h80, 32'h0100_1802, 2'b10);
        rd(8'h80, 32'h0200_0801);
        node_cfg_lock = 1'b0;
        wr(8'h80, 32'h0000_1802, 2'b11);
        tok_cmd = 1'b1;
        run_len(2, 1'b1, n);
        run_len(2, 1'b0, n);
        chk("symbol gap", 32'd2, n);
        tok_cmd = 1'b0;
        n = 0;
        @(negedge clk);
        while (link_ctl.token_ready !== 1'b1 && n < 50) begin
            n++;
            @(negedge clk);
        end
        chk("token gap", 32'd2, n);
    endtask : t_link

    task automatic t_resets();
        int ks [4] = '{5, 0, 1, 2};
        int kt [3] = '{6, 3, 4};
        int n;
        foreach (ks[i]) begin
            wr(8'h51, 32'h0C, 2'b11);
            fire(ks[i]);
            run_len(0, 1'b1, n);
            chk("system reset length", 32'd16, n);
            repeat (40) @(negedge clk);
            rd(8'h51, 32'h19);
        end
        foreach (kt[i]) begin
            fire(kt[i]);
            run_len(1, 1'b1, n);
            chk("tile reset length", 32'd25, n);
            chk("no system reset", 32'h0, sys_reset_out);
            repeat (5) @(negedge clk);
        end
    endtask : t_resets

    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    initial begin
        reset = 1'b1;
        cfg_req = '0;
        src = 5'h00;
        node_cfg_lock = 1'b0;
        slow = 1'b0;
        err_cmd = 1'b0;
        tok_cmd = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        t_regs();
        t_freq();
        t_link();
        t_resets();
        wrap_up();
    end
endmodule : testbench
